/* design/srcc_strap_capture.v */
// Strap capture, reset stretch, factory default button and zero-cross timing
`timescale 1ns/1ps
`include "srcc_consts.vh"
module srcc_strap_capture #(
    parameter STRETCH_CYC = `SRCC_STRETCH_CYC,
    parameter FD_MIN_CYC = `SRCC_FD_MIN_CYC,
    parameter FD_MAX_CYC = `SRCC_FD_MAX_CYC
) (
    input wire i_clk,
    input wire i_rst_b,
    input wire [1:0] i_host_if_type_strap,
    input wire i_autoneg_enable_strap,
    input wire i_isolate_default_strap,
    input wire [1:0] i_speed_sel_strap,
    input wire i_mgmt_addr_bit3_strap,
    input wire i_cfg_source_strap,
    input wire i_mgmt_addr_bit4_strap,
    input wire i_host_role_strap,
    input wire i_bootcode_source_strap,
    input wire i_duplex_strap,
    input wire i_factory_button_b,
    input wire i_line_zero_cross_in,
    input wire [2:0] i_led_drive,
    output reg o_cfg_valid,
    output reg [1:0] o_host_if_type,
    output reg o_host_if_mii,
    output reg o_host_is_mac,
    output reg o_autoneg_en,
    output reg o_isolate,
    output reg [1:0] o_speed_sel,
    output reg o_speed_100,
    output reg o_full_duplex,
    output reg [4:0] o_mgmt_addr,
    output reg o_boot_from_flash,
    output reg o_boot_unsupported,
    output reg o_strap_drive_en,
    output reg [2:0] o_led_out,
    output reg [2:0] o_led_oe,
    output reg o_ext_phy_clear_n,
    output reg o_factory_default,
    output reg o_zc_edge,
    output reg [`SRCC_ZC_W-1:0] o_line_period
);

////////////////////////////////////////////////////////////////////////////////
// Capture a couple of cycles after release so straps are settled
reg [1:0] cap_cnt_reg;
reg captured_reg;
wire cap_now = !captured_reg && (cap_cnt_reg == `SRCC_CAP_DELAY);

always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
        cap_cnt_reg <= 2'h0;
        captured_reg <= 1'b0;
    end else if (!captured_reg) begin
        cap_cnt_reg <= cap_cnt_reg + 2'h1;
        if (cap_now) begin
            captured_reg <= 1'b1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Strap decode; only the capture edge lets these reach the outputs
reg [1:0] host_if_type_next;
reg host_if_mii_next;
reg host_is_mac_next;
reg autoneg_en_next;
reg isolate_next;
reg [1:0] speed_sel_next;
reg speed_100_next;
reg full_duplex_next;
reg [4:0] mgmt_addr_next;
reg boot_from_flash_next;
reg boot_unsupported_next;

always @* begin
    host_if_type_next = i_host_if_type_strap;
    host_if_mii_next = &i_host_if_type_strap;
    host_is_mac_next = i_host_role_strap;
    autoneg_en_next = i_autoneg_enable_strap;
    isolate_next = i_isolate_default_strap;
    speed_sel_next = i_speed_sel_strap;
    speed_100_next = (i_speed_sel_strap == `SRCC_SPEED_100);
    full_duplex_next = i_duplex_strap;
    mgmt_addr_next = `SRCC_MGMT_ADDR_BASE |
        {i_mgmt_addr_bit4_strap, i_mgmt_addr_bit3_strap, 3'h0};
    // Only both boot bits high is a supported source pair
    boot_from_flash_next = i_bootcode_source_strap & i_cfg_source_strap;
    boot_unsupported_next = ~boot_from_flash_next;
end

////////////////////////////////////////////////////////////////////////////////
// Straps latched once; values are constants until next reset
always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
        o_cfg_valid <= 1'b0;
        o_host_if_type <= `SRCC_RST_HOST_IF;
        o_host_if_mii <= 1'b1;
        o_host_is_mac <= 1'b1;
        o_autoneg_en <= 1'b1;
        o_isolate <= 1'b0;
        o_speed_sel <= `SRCC_SPEED_100;
        o_speed_100 <= 1'b1;
        o_full_duplex <= 1'b1;
        o_mgmt_addr <= `SRCC_RST_MGMT_ADDR;
        o_boot_from_flash <= 1'b1;
        o_boot_unsupported <= 1'b0;
    end else if (cap_now) begin
        o_cfg_valid <= 1'b1;
        o_host_if_type <= host_if_type_next;
        o_host_if_mii <= host_if_mii_next;
        o_host_is_mac <= host_is_mac_next;
        o_autoneg_en <= autoneg_en_next;
        o_isolate <= isolate_next;
        o_speed_sel <= speed_sel_next;
        o_speed_100 <= speed_100_next;
        o_full_duplex <= full_duplex_next;
        o_mgmt_addr <= mgmt_addr_next;
        o_boot_from_flash <= boot_from_flash_next;
        o_boot_unsupported <= boot_unsupported_next;
    end
end

////////////////////////////////////////////////////////////////////////////////
// LED pins: only driven after capture, never during strap sampling
always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
        o_strap_drive_en <= 1'b0;
        o_led_out <= 3'h0;
        o_led_oe <= 3'h0;
    end else begin
        o_strap_drive_en <= captured_reg;
        o_led_out <= i_led_drive;
        o_led_oe <= {3{captured_reg}};
    end
end

////////////////////////////////////////////////////////////////////////////////
// PHY reset held past our own release by a stretch count
reg [`SRCC_CNT_W-1:0] stretch_reg;
always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
        stretch_reg <= {`SRCC_CNT_W{1'b0}};
        o_ext_phy_clear_n <= 1'b0;
    end else if (stretch_reg < STRETCH_CYC[`SRCC_CNT_W-1:0]) begin
        stretch_reg <= stretch_reg + {{(`SRCC_CNT_W-1){1'b0}}, 1'b1};
        o_ext_phy_clear_n <= 1'b0;
    end else begin
        o_ext_phy_clear_n <= 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Factory default: judged on release, so a long hold does nothing
reg [`SRCC_CNT_W-1:0] press_reg;
reg btn_q_reg;
always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
        press_reg <= {`SRCC_CNT_W{1'b0}};
        btn_q_reg <= 1'b1;
        o_factory_default <= 1'b0;
    end else begin
        btn_q_reg <= i_factory_button_b;
        o_factory_default <= 1'b0;
        if (captured_reg && !btn_q_reg) begin
            // Saturating, so an endless hold never wraps into the window
            if (press_reg != {`SRCC_CNT_W{1'b1}}) begin
                press_reg <= press_reg + {{(`SRCC_CNT_W-1){1'b0}}, 1'b1};
            end
        end else begin
            press_reg <= {`SRCC_CNT_W{1'b0}};
            if (press_reg > FD_MIN_CYC[`SRCC_CNT_W-1:0] &&
                press_reg < FD_MAX_CYC[`SRCC_CNT_W-1:0]) begin
                o_factory_default <= 1'b1;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Zero cross: rising edge pulse and measured line period
reg zc_q_reg;
reg [`SRCC_ZC_W-1:0] zc_cnt_reg;
always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
        // Unused input idles high, so no false edge after reset
        zc_q_reg <= 1'b1;
        zc_cnt_reg <= {`SRCC_ZC_W{1'b0}};
        o_zc_edge <= 1'b0;
        o_line_period <= {`SRCC_ZC_W{1'b0}};
    end else begin
        zc_q_reg <= i_line_zero_cross_in;
        o_zc_edge <= i_line_zero_cross_in & ~zc_q_reg;
        if (i_line_zero_cross_in & ~zc_q_reg) begin
            o_line_period <= zc_cnt_reg;
            // The edge cycle itself counts, so the period is edge to edge
            zc_cnt_reg <= {{(`SRCC_ZC_W-1){1'b0}}, 1'b1};
        end else if (zc_cnt_reg != {`SRCC_ZC_W{1'b1}}) begin
            zc_cnt_reg <= zc_cnt_reg + {{(`SRCC_ZC_W-1){1'b0}}, 1'b1};
        end
    end
end

endmodule // srcc_strap_capture

/* design/srcc_consts.vh */
// Constants for the strap capture and reset configuration block
`ifndef SRCC_CONSTS_VH
`define SRCC_CONSTS_VH
`define SRCC_CLK_PERIOD_NS 10
`define SRCC_STRETCH_MS 10
`define SRCC_STRETCH_CYC (`SRCC_STRETCH_MS * (1000000 / `SRCC_CLK_PERIOD_NS))
`define SRCC_FD_MIN_MS 500
`define SRCC_FD_MAX_MS 3000
// Divide first: 3000 ms in ns would overflow a 32-bit constant
`define SRCC_FD_MIN_CYC (`SRCC_FD_MIN_MS * (1000000 / `SRCC_CLK_PERIOD_NS))
`define SRCC_FD_MAX_CYC (`SRCC_FD_MAX_MS * (1000000 / `SRCC_CLK_PERIOD_NS))
`define SRCC_CNT_W 29
`define SRCC_STRAP_W 11
`define SRCC_CAP_DELAY 2'h2
`define SRCC_MGMT_ADDR_BASE 5'h00
`define SRCC_RST_HOST_IF 2'h3
`define SRCC_RST_MGMT_ADDR 5'h08
`define SRCC_SPEED_10 2'h0
`define SRCC_SPEED_100 2'h1
`define SRCC_ZC_W 24
`endif

/* testbench/srcc_board_model.sv */
// Board strap resistors facing the strap capture block
`timescale 1ns/1ps
module srcc_board_model (
    input wire i_drive_en,
    input wire [11:0] i_drive_val,
    output wire [11:0] o_strap
);
    // Resistor straps override the pulls; a rail tie would fight the LED drivers
    assign o_strap = i_drive_en ? i_drive_val : 12'he77;
endmodule // srcc_board_model

/* testbench/srcc_strap_capture_asserts.sv */
// Checker for the strap capture block
`timescale 1ns/1ps
module srcc_strap_capture_asserts (
    input wire i_clk,
    input wire i_rst_b,
    input wire o_cfg_valid,
    input wire [1:0] o_host_if_type,
    input wire o_host_if_mii,
    input wire [1:0] o_speed_sel,
    input wire o_speed_100,
    input wire [4:0] o_mgmt_addr,
    input wire o_ext_phy_clear_n,
    input wire [2:0] o_led_oe,
    input wire o_zc_edge
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    a_clean_release: assert property ($rose(i_rst_b) |-> !o_cfg_valid)
        else $error("valid too early");
    a_capture_soon: assert property ($rose(i_rst_b) |-> ##[1:4] o_cfg_valid)
        else $error("no capture");
    a_cfg_frozen: assert property (o_cfg_valid |=> o_cfg_valid && $stable(o_mgmt_addr)
        && $stable(o_host_if_type)) else $error("config moved");
    a_mii_decode: assert property (o_host_if_mii == (o_host_if_type == 2'h3))
        else $error("mii decode");
    a_speed_decode: assert property (o_speed_100 == (o_speed_sel == 2'h1))
        else $error("speed decode");
    a_addr_low_zero: assert property (o_mgmt_addr[2:0] == 3'h0)
        else $error("address low bits");
    a_phy_clear_stretch: assert property ($rose(i_rst_b) |->
        !o_ext_phy_clear_n [*8] ##[1:40] o_ext_phy_clear_n) else $error("phy clear stretch");
    a_zc_single: assert property (o_zc_edge |=> !o_zc_edge)
        else $error("zero cross pulse");
    a_led_after_cap: assert property (|o_led_oe |-> o_cfg_valid)
        else $error("led driven before capture");
endmodule // srcc_strap_capture_asserts
bind srcc_strap_capture srcc_strap_capture_asserts i_chk (.i_clk, .i_rst_b, .o_cfg_valid,
    .o_host_if_type, .o_host_if_mii, .o_speed_sel, .o_speed_100, .o_mgmt_addr,
    .o_ext_phy_clear_n, .o_led_oe, .o_zc_edge);

/* testbench/testbench.sv */
// Self-checking bench for the strap capture block
`timescale 1ns/1ps
module testbench;
    reg i_clk = 1'b0;
    reg i_rst_b = 1'b0;
    reg den = 1'b0;
    reg [11:0] dval = 12'h000;
    reg btn_b = 1'b1;
    reg zc = 1'b0;
    reg [2:0] led = 3'h0;
    reg [2:0] last;
    reg [31:0] rng = 32'h47;
    wire [11:0] s;
    wire [4:0] addr;
    wire [2:0] lout, loe;
    wire [1:0] hif, ssel;
    wire [23:0] period;
    wire valid, mii, mac, an, iso, sp, dup, fl, unsup, sde, pclr, fd, zce;
    localparam STRETCH = 20, FD_MIN = 10, FD_MAX = 30;
    integer bad_count = 0, cmp_count = 0, cyc = 0, i, n, k;
    always #5 i_clk = ~i_clk;
    srcc_board_model i_srcc_board_model (.i_drive_en(den), .i_drive_val(dval), .o_strap(s));
    srcc_strap_capture #(.STRETCH_CYC(STRETCH), .FD_MIN_CYC(FD_MIN), .FD_MAX_CYC(FD_MAX))
        i_srcc_strap_capture (
        .i_clk, .i_rst_b, .i_host_if_type_strap(s[11:10]), .i_autoneg_enable_strap(s[9]),
        .i_isolate_default_strap(s[8]), .i_speed_sel_strap(s[7:6]), .i_mgmt_addr_bit3_strap(s[5]),
        .i_cfg_source_strap(s[4]), .i_mgmt_addr_bit4_strap(s[3]), .i_host_role_strap(s[2]),
        .i_bootcode_source_strap(s[1]), .i_duplex_strap(s[0]), .i_factory_button_b(btn_b),
        .i_line_zero_cross_in(zc), .i_led_drive(led), .o_cfg_valid(valid), .o_host_if_type(hif),
        .o_host_if_mii(mii), .o_host_is_mac(mac), .o_autoneg_en(an), .o_isolate(iso),
        .o_speed_sel(ssel), .o_speed_100(sp), .o_full_duplex(dup), .o_mgmt_addr(addr),
        .o_boot_from_flash(fl), .o_boot_unsupported(unsup), .o_strap_drive_en(sde),
        .o_led_out(lout), .o_led_oe(loe), .o_ext_phy_clear_n(pclr), .o_factory_default(fd),
        .o_zc_edge(zce), .o_line_period(period));
    function [31:0] xs(input [31:0] x);
        xs = x ^ (x << 13);
        xs = xs ^ (xs >> 17);
        xs = xs ^ (xs << 5);
    endfunction
    // Strap vector to {mii, mac, an, iso, 100M, full, addr, flash}
    function [11:0] exp_cfg(input [11:0] v);
        exp_cfg = {v[11] & v[10], v[2], v[9], v[8], v[7:6] == 2'h1, v[0], v[3], v[5], 3'h0,
            v[1] & v[4]};
    endfunction
    task chk(input [31:0] got, input [31:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task end_sim;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Straps flip right after capture to prove they are not resampled
    task boot(input e, input [11:0] v);
        reg [11:0] w;
        reg [11:0] x;
        w = e ? v : 12'he77;
        x = exp_cfg(w);
        @(posedge i_clk);
        den <= e;
        dval <= v;
        i_rst_b <= 1'b0;
        repeat (10) @(posedge i_clk);
        @(negedge i_clk);
        chk({valid, pclr, sde, loe}, 6'h00);
        @(posedge i_clk);
        i_rst_b <= 1'b1;
        // Capture lands on the third edge after release
        repeat (3) @(negedge i_clk);
        chk(valid, 1'b0);
        @(negedge i_clk);
        chk(valid, 1'b1);
        @(posedge i_clk);
        den <= 1'b1;
        dval <= ~v;
        repeat (3) @(negedge i_clk);
        chk({mii, mac, an, iso, sp, dup}, x[11:6]);
        chk({addr, fl}, x[5:0]);
        chk({hif, ssel, unsup}, {w[11:10], w[7:6], ~(w[1] & w[4])});
        chk({sde, loe}, 4'hf);
        chk(pclr, 1'b0);
    endtask
    initial begin
        boot(1'b0, 12'he77);
        boot(1'b1, 12'h000);
        for (i = 0; i < 12; i = i + 1) begin
            rng = xs(rng);
            boot(1'b1, rng[11:0]);
        end
        // Last release was STRETCH + 2 negedges before the first high one
        repeat (STRETCH - 6) @(negedge i_clk);
        chk(pclr, 1'b0);
        @(negedge i_clk);
        chk(pclr, 1'b1);
        for (i = 0; i < 7; i = i + 1) begin
            n = (i == 0) ? 20 : (i == 1) ? 5 : (i == 2) ? 45 : (i == 3) ? FD_MIN :
                (i == 4) ? FD_MIN + 1 : (i == 5) ? FD_MAX - 1 : FD_MAX;
            k = 0;
            @(posedge i_clk) btn_b <= 1'b0;
            repeat (n) @(posedge i_clk);
            btn_b <= 1'b1;
            repeat (6) begin @(negedge i_clk); k = k + fd; end
            chk(k, n > FD_MIN && n < FD_MAX);
        end
        k = 0;
        for (i = 0; i < 64; i = i + 1) begin
            @(posedge i_clk);
            last = led;
            rng = xs(rng);
            led <= rng[2:0];
            zc <= i[3];
            @(negedge i_clk);
            chk(lout, last);
            k = k + zce;
        end
        repeat (4) begin @(negedge i_clk); k = k + zce; end
        chk(k, 4);
        chk(period, 32'h10);
        end_sim;
    end
    always @(posedge i_clk) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            bad_count = bad_count + 1;
            end_sim;
        end
    end
endmodule // testbench
